// >>> sdag_top.v
// debug authentication gate: key registers, comparison, wake and halt control
// assumes an axi4-lite master on the debug private space, synchronous inputs
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "sdag_regs.vh"
module sdag_top #(
  parameter WAIT_CYC = `SDAG_WAIT_CYC
) (
  input wire mclk,
  input wire reset,
  input wire ce,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [127:0] stored_unlock_code,
  input wire chip_reset_req,
  input wire cpu_sleeping,
  input wire cpu_halted,
  input wire erase_done,
  input wire [1:0] pc_mode,
  input wire [1:0] supply,
  input wire [2:0] lp_mode,
  input wire in_transit,
  input wire [1:0] pc_req,
  input wire pc_req_valid,
  input wire sysreset_req_wr,
  output reg debug_grant_ff,
  output reg mem_port_status_ff,
  output reg external_halt_request_ff,
  output reg debug_wake_request_ff,
  output reg wake_no_exec_ff,
  output reg erase_start_ff,
  output reg sysreset_req_ok_ff,
  output reg pc_apply_ff,
  output reg [1:0] pc_apply_mode_ff,
  output reg backbias_emul_ff,
  output reg in_debug_ff
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_READY = 2'h2;
  localparam CW = 16;

  reg [31:0] key_ff [0:3];
  reg [1:0] next_word_ff;
  reg keys_dirty_ff;
  reg [127:0] code_ff;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [CW-1:0] wait_ff;
  reg cmp_start_ff;
  reg debugger_enable_ff;
  reg aw_held_ff;
  reg w_held_ff;
  reg [11:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg clkstop_ff;
  wire cmp_done;
  wire cmp_pass;
  wire cmp_erase;
  wire entry_ok;
  wire bus_ok;
  wire pc_change_ok;
  wire wr_fire;
  wire [11:0] wa;
  wire [31:0] wd;
  wire full_word;

  // which key word an address selects, shared by write and read decode
  function [2:0] key_sel;
    input [11:0] a;
    begin
      if (a == `SDAG_ADDR_KEY0) key_sel = 3'h4;
      else if (a == `SDAG_ADDR_KEY1) key_sel = 3'h5;
      else if (a == `SDAG_ADDR_KEY2) key_sel = 3'h6;
      else if (a == `SDAG_ADDR_KEY3) key_sel = 3'h7;
      else key_sel = 3'h0;
    end
  endfunction

  sdag_key_cmp u_cmp (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .start(cmp_start_ff),
    .key({key_ff[0], key_ff[1], key_ff[2], key_ff[3]}),
    .code(code_ff),
    .done_ff(cmp_done),
    .pass_ff(cmp_pass),
    .erase_ff(cmp_erase)
  );

  sdag_pwr_gate u_pwr (
    .pc_mode(pc_mode),
    .supply(supply),
    .lp_mode(lp_mode),
    .in_transit(in_transit),
    .in_debug(in_debug_ff),
    .pc_req(pc_req),
    .entry_ok(entry_ok),
    .bus_ok(bus_ok),
    .pc_change_ok(pc_change_ok)
  );

  // a write fires once both address and data are held or arriving
  assign wa = aw_held_ff ? awaddr_ff : s_axi_awaddr;
  assign wd = w_held_ff ? wdata_ff : s_axi_wdata;
  assign wr_fire = (aw_held_ff || s_axi_awvalid) && (w_held_ff || s_axi_wvalid) && !s_axi_bvalid;
  assign full_word = w_held_ff || (s_axi_wstrb == 4'hF);

  // write channel handshake, address and data taken in either order
  always @(posedge mclk) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h00000000;
    end else if (ce) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_fire) begin
        s_axi_awready <= !aw_held_ff;
        s_axi_wready <= !w_held_ff;
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // unmapped addresses answer slverr
        s_axi_bresp <= (key_sel(wa) != 3'h0 || wa == `SDAG_ADDR_CTRL ||
          wa == `SDAG_ADDR_DBGCTL) ? 2'h0 : 2'h2;
      end else begin
        if (s_axi_awvalid && !aw_held_ff && !s_axi_awready) begin
          aw_held_ff <= 1'b1;
          awaddr_ff <= s_axi_awaddr;
          s_axi_awready <= 1'b1;
        end
        if (s_axi_wvalid && !w_held_ff && !s_axi_wready) begin
          w_held_ff <= 1'b1;
          wdata_ff <= s_axi_wdata;
          s_axi_wready <= 1'b1;
        end
      end
    end
  end

  // key words; out-of-order writes are ignored, fourth word triggers compare
  always @(posedge mclk) begin
    if (reset) begin
      key_ff[0] <= `SDAG_KEY_RST;
      key_ff[1] <= `SDAG_KEY_RST;
      key_ff[2] <= `SDAG_KEY_RST;
      key_ff[3] <= `SDAG_KEY_RST;
      next_word_ff <= 2'h0;
      keys_dirty_ff <= 1'b0;
    end else if (ce && wr_fire && key_sel(wa) != 3'h0 && full_word) begin
      if (key_sel(wa) == {1'b1, next_word_ff}) begin
        key_ff[next_word_ff] <= wd;
        next_word_ff <= next_word_ff + 2'h1;
        keys_dirty_ff <= 1'b1;
      end
    end
  end

  // stored code is captured only across a chip reset
  always @(posedge mclk) begin
    if (reset)
      code_ff <= 128'h0;
    else if (ce && state_ff == ST_IDLE)
      code_ff <= stored_unlock_code;
  end

  // sequencer: settle wait after reset release, then compare on demand
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = ST_WAIT;
      ST_WAIT: if (wait_ff == WAIT_CYC[CW-1:0]) nxt_state = ST_READY;
      default: nxt_state = ST_READY;
    endcase
  end

  always @(posedge mclk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      wait_ff <= {CW{1'b0}};
      cmp_start_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      cmp_start_ff <= 1'b0;
      if (state_ff == ST_WAIT)
        wait_ff <= wait_ff + {{(CW-1){1'b0}}, 1'b1};
      // first compare after the wait covers an all-ones code with reset keys
      if (state_ff == ST_WAIT && nxt_state == ST_READY)
        cmp_start_ff <= 1'b1;
      else if (state_ff == ST_READY && wr_fire && key_sel(wa) == 3'h7 &&
          next_word_ff == 2'h3 && full_word)
        cmp_start_ff <= 1'b1;
    end
  end

  // result, grant and port status; held failed until a compare completes
  always @(posedge mclk) begin
    if (reset) begin
      debug_grant_ff <= 1'b0;
      mem_port_status_ff <= 1'b0;
      erase_start_ff <= 1'b0;
      in_debug_ff <= 1'b0;
      debugger_enable_ff <= 1'b0;
    end else if (ce) begin
      erase_start_ff <= 1'b0;
      if (cmp_done) begin
        debug_grant_ff <= cmp_pass;
        mem_port_status_ff <= cmp_pass && (bus_ok || !in_debug_ff);
        erase_start_ff <= cmp_erase;
      end else
        mem_port_status_ff <= debug_grant_ff && (bus_ok || !in_debug_ff);
      if (debug_grant_ff && !in_debug_ff && entry_ok)
        in_debug_ff <= 1'b1;
      if (wr_fire && wa == `SDAG_ADDR_DBGCTL && full_word)
        debugger_enable_ff <= wd[`SDAG_DC_ENABLE];
    end
  end

  // halt and wake requests; hardware clear on halt only when no write sets it
  always @(posedge mclk) begin
    if (reset) begin
      external_halt_request_ff <= 1'b0;
      debug_wake_request_ff <= 1'b0;
      wake_no_exec_ff <= 1'b0;
      sysreset_req_ok_ff <= 1'b1;
      clkstop_ff <= 1'b0;
    end else if (ce) begin
      if (wr_fire && wa == `SDAG_ADDR_CTRL && full_word) begin
        external_halt_request_ff <= wd[`SDAG_CT_HALT];
        debug_wake_request_ff <= wd[`SDAG_CT_WAKE];
        wake_no_exec_ff <= wd[`SDAG_CT_HALT] && wd[`SDAG_CT_WAKE];
      end else if (cpu_halted)
        external_halt_request_ff <= 1'b0;
      if (keys_dirty_ff)
        sysreset_req_ok_ff <= 1'b0;
      // a completion in the same cycle as a new erase start must not be lost
      if (erase_done)
        clkstop_ff <= 1'b1;
      else if (erase_start_ff)
        clkstop_ff <= 1'b0;
    end
  end

  // power control requests filtered by debug state
  always @(posedge mclk) begin
    if (reset) begin
      pc_apply_ff <= 1'b0;
      pc_apply_mode_ff <= `SDAG_PC_NORMAL;
      backbias_emul_ff <= 1'b0;
    end else if (ce) begin
      pc_apply_ff <= 1'b0;
      if (pc_req_valid && pc_change_ok) begin
        // in debug, back-bias is only flagged: the real power mode is left unchanged
        if (in_debug_ff && (pc_req == `SDAG_PC_BACKBIAS || pc_mode == `SDAG_PC_BACKBIAS)) begin
          backbias_emul_ff <= (pc_req == `SDAG_PC_BACKBIAS);
        end else begin
          pc_apply_ff <= 1'b1;
          pc_apply_mode_ff <= pc_req;
        end
      end
    end
  end

  // read channel; one read in flight, unmapped reads give slverr
  always @(posedge mclk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (ce) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        s_axi_rdata <= 32'h00000000;
        if (s_axi_araddr == `SDAG_ADDR_STATUS)
          s_axi_rdata <= {29'h0, clkstop_ff, cpu_sleeping, debug_grant_ff};
        else if (s_axi_araddr == `SDAG_ADDR_CTRL)
          s_axi_rdata <= {23'h0, debug_wake_request_ff, 7'h0, external_halt_request_ff};
        else if (s_axi_araddr == `SDAG_ADDR_PWR)
          s_axi_rdata <= {24'h0, in_transit, lp_mode, supply, pc_mode};
        else if (s_axi_araddr == `SDAG_ADDR_DBGCTL)
          s_axi_rdata <= {30'h0, in_debug_ff, debugger_enable_ff};
        else if (key_sel(s_axi_araddr) != 3'h0)
          s_axi_rdata <= 32'h00000000; // key words are write-only
        else
          s_axi_rresp <= 2'h2;
      end
    end
  end
endmodule // sdag_top

// >>> sdag_regs.vh
// register map, field positions, reset values and timing counts of the debug gate
// assumes inclusion by the design, checker and bench files of the debug authentication gate
`ifndef SDAG_REGS_VH
`define SDAG_REGS_VH
// axi4-lite byte addresses
`define SDAG_ADDR_KEY0 12'h000
`define SDAG_ADDR_KEY1 12'h100
`define SDAG_ADDR_KEY2 12'h200
`define SDAG_ADDR_KEY3 12'h300
`define SDAG_ADDR_STATUS 12'h400
`define SDAG_ADDR_CTRL 12'h410
`define SDAG_ADDR_PWR 12'h420
`define SDAG_ADDR_DBGCTL 12'h430
// status fields
`define SDAG_ST_PASS 0
`define SDAG_ST_SLEEP 1
`define SDAG_ST_CLKSTOP 2
// control fields
`define SDAG_CT_HALT 0
`define SDAG_CT_WAKE 8
// power-state register fields: [1:0] power control, [3:2] supply, [6:4] low power, [7] transit
`define SDAG_PC_BOOST 2'h0
`define SDAG_PC_NORMAL 2'h1
`define SDAG_PC_BACKBIAS 2'h2
`define SDAG_SUP_FULL 2'h0
`define SDAG_LP_RUN 3'h0
`define SDAG_LP_SLEEP 3'h1
// debug control register fields
`define SDAG_DC_ENABLE 0
`define SDAG_DC_DEBUG 1
// reset values
`define SDAG_KEY_RST 32'hFFFFFFFF
`define SDAG_STATUS_RST 32'h00000000
// post-reset settle wait before comparison
`define SDAG_WAIT_NS 1000
`define SDAG_CLK_NS 20
`define SDAG_WAIT_CYC ((`SDAG_WAIT_NS + `SDAG_CLK_NS - 1) / `SDAG_CLK_NS)
// mass erase pattern
`define SDAG_ERASE_KEY 128'h414C6552415345FFFFFFFFFFFFFFFFFF
`endif

// >>> sdag_key_cmp.v
// 128-bit key comparator with stored-code classification
// assumes key and code are stable while start is pulsed
`timescale 1ns/100ps
`include "sdag_regs.vh"
module sdag_key_cmp (
  input wire mclk,
  input wire reset,
  input wire ce,
  input wire start,
  input wire [127:0] key,
  input wire [127:0] code,
  output reg done_ff,
  output reg pass_ff,
  output reg erase_ff
);
  // bit 127 clear locks out for good; all ones needs no key
  always @(posedge mclk) begin
    if (reset) begin
      done_ff <= 1'b0;
      pass_ff <= 1'b0;
      erase_ff <= 1'b0;
    end else if (ce) begin
      done_ff <= start;
      if (start) begin
        if (!code[127])
          pass_ff <= 1'b0;
        else if (&code)
          pass_ff <= 1'b1;
        else
          pass_ff <= (key == code);
        erase_ff <= (key == `SDAG_ERASE_KEY);
      end
    end
  end
endmodule // sdag_key_cmp

// >>> sdag_pwr_gate.v
// power-state qualifier for debug entry, bus access and mode changes
// assumes power state fields are synchronous to mclk
`timescale 1ns/100ps
`include "sdag_regs.vh"
module sdag_pwr_gate (
  input wire [1:0] pc_mode,
  input wire [1:0] supply,
  input wire [2:0] lp_mode,
  input wire in_transit,
  input wire in_debug,
  input wire [1:0] pc_req,
  output wire entry_ok,
  output wire bus_ok,
  output wire pc_change_ok
);
  wire run_or_sleep;
  assign run_or_sleep = (lp_mode == `SDAG_LP_RUN) || (lp_mode == `SDAG_LP_SLEEP);
  // entry only from boost, or normal with full supply
  assign entry_ok = !in_transit && run_or_sleep && ((pc_mode == `SDAG_PC_BOOST) ||
    ((pc_mode == `SDAG_PC_NORMAL) && (supply == `SDAG_SUP_FULL)));
  assign bus_ok = !in_transit && run_or_sleep;
  // boost/normal swaps frozen in debug; normal<->back-bias allowed
  assign pc_change_ok = !in_debug ||
    !((pc_mode == `SDAG_PC_BOOST) && (pc_req == `SDAG_PC_NORMAL)) &&
    !((pc_mode == `SDAG_PC_NORMAL) && (pc_req == `SDAG_PC_BOOST));
endmodule // sdag_pwr_gate

// >>> sdag_props.sv
// checker on the ports of the debug authentication gate
// assumes one clock mclk with synchronous active-high reset
`timescale 1ns/100ps
`include "sdag_regs.vh"
module sdag_props #(
  parameter WAIT_CYC = 4
) (
  input wire mclk,
  input wire reset,
  input wire ce,
  input wire s_axi_wvalid,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire cpu_halted,
  input wire [1:0] pc_mode,
  input wire [1:0] supply,
  input wire [2:0] lp_mode,
  input wire in_transit,
  input wire [1:0] pc_req,
  input wire pc_req_valid,
  input wire debug_grant_ff,
  input wire mem_port_status_ff,
  input wire external_halt_request_ff,
  input wire erase_start_ff,
  input wire sysreset_req_ok_ff,
  input wire pc_apply_ff,
  input wire backbias_emul_ff,
  input wire in_debug_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // power states from which debug entry may latch
  wire entry_now = !in_transit && lp_mode <= `SDAG_LP_SLEEP && (pc_mode == `SDAG_PC_BOOST ||
    (pc_mode == `SDAG_PC_NORMAL && supply == `SDAG_SUP_FULL));
  wire in_swap = (pc_mode == `SDAG_PC_BOOST && pc_req == `SDAG_PC_NORMAL) ||
    (pc_mode == `SDAG_PC_NORMAL && pc_req == `SDAG_PC_BOOST);
  // bus status follows the pass flag, masked in debug during transit or outside run and sleep
  wire bus_now = !in_transit && lp_mode <= `SDAG_LP_SLEEP;
  property p_mirror;
    mem_port_status_ff == (debug_grant_ff && ($past(bus_now) || !$past(in_debug_ff)));
  endproperty
  a_mirror: assert property (p_mirror) else $error("port status differs from pass flag");
  property p_start_fail; $fell(reset) |-> !debug_grant_ff [*4]; endproperty
  a_start_fail: assert property (p_start_fail) else $error("pass before settle");
  property p_entry; $rose(in_debug_ff) |-> $past(debug_grant_ff) && $past(entry_now); endproperty
  a_entry: assert property (p_entry) else $error("debug entry from bad state");
  property p_swap; in_debug_ff && pc_req_valid && in_swap |=> !pc_apply_ff ##1 !pc_apply_ff;
  endproperty
  a_swap: assert property (p_swap) else $error("boost normal swap applied");
  property p_bb;
    in_debug_ff && pc_req_valid && pc_mode == `SDAG_PC_NORMAL && pc_req == `SDAG_PC_BACKBIAS
      |-> ##[1:2] backbias_emul_ff;
  endproperty
  a_bb: assert property (p_bb) else $error("back-bias not emulated");
  property p_lock; !sysreset_req_ok_ff |=> !sysreset_req_ok_ff; endproperty
  a_lock: assert property (p_lock) else $error("reset request unlocked");
  property p_halt;
    ce && external_halt_request_ff && cpu_halted && !s_axi_wvalid
      |-> ##[1:2] !external_halt_request_ff;
  endproperty
  a_halt: assert property (p_halt) else $error("halt request not cleared");
  property p_erase; erase_start_ff |=> !erase_start_ff; endproperty
  a_erase: assert property (p_erase) else $error("erase start too long");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule // sdag_props
bind sdag_top sdag_props #(.WAIT_CYC(WAIT_CYC)) u_props (.mclk, .reset, .ce, .s_axi_wvalid,
  .s_axi_bvalid, .s_axi_bready, .cpu_halted, .pc_mode, .supply, .lp_mode, .in_transit,
  .pc_req, .pc_req_valid, .debug_grant_ff, .mem_port_status_ff, .external_halt_request_ff,
  .erase_start_ff, .sysreset_req_ok_ff, .pc_apply_ff, .backbias_emul_ff, .in_debug_ff);

// >>> sdag_emu.sv
// emulator model: axi4-lite master into the debug private space
// assumes the bench calls wr and rd just after a rising edge, one at a time
`timescale 1ns/100ps
module sdag_emu (
  input wire mclk,
  output logic [11:0] awaddr = 12'h000,
  output logic awvalid = 1'b0,
  input wire awready,
  output logic [31:0] wdata = 32'h00000000,
  output logic [3:0] wstrb = 4'hF,
  output logic wvalid = 1'b0,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  output logic bready = 1'b0,
  output logic [11:0] araddr = 12'h000,
  output logic arvalid = 1'b0,
  input wire arready,
  input wire [31:0] rdata,
  input wire rvalid,
  output logic rready = 1'b0
);
  int stall = 0; // late bready/rready, set by the bench
  // released payload is inverted so stale values never look valid
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge mclk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    repeat (stall) @(posedge mclk);
    bready <= 1'b1;
    do @(posedge mclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    repeat (stall) @(posedge mclk);
    rready <= 1'b1;
    do @(posedge mclk); while (!rvalid);
    d = rdata;
    rready <= 1'b0;
  endtask
endmodule // sdag_emu

// >>> tb_top.sv
// bench of the debug authentication gate: keys, entry, power, control
// assumes the emulator model drives the register bus
`timescale 1ns/100ps
`include "sdag_regs.vh"
module tb_top;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, pc_apply_mode_ff, resp;
  logic [127:0] stored_unlock_code = {4{32'hFFFFFFFF}};
  logic [127:0] kk;
  logic cpu_sleeping = 1'b0, cpu_halted = 1'b0, erase_done = 1'b0, pc_req_valid = 1'b0;
  logic [1:0] pc_mode = `SDAG_PC_NORMAL, supply = `SDAG_SUP_FULL, pc_req = 2'h0;
  logic [2:0] lp_mode = 3'h2; // snooze during the first reset
  logic debug_grant_ff, mem_port_status_ff, external_halt_request_ff, debug_wake_request_ff;
  logic wake_no_exec_ff, erase_start_ff, sysreset_req_ok_ff, pc_apply_ff, backbias_emul_ff;
  logic in_debug_ff;
  logic ce = 1'b1;
  logic erase_seen = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] rnd = 32'h0000003C;
  int bad_count = 0;
  int checked = 0;
  always #10 mclk = ~mclk;
  sdag_top #(.WAIT_CYC(4)) uut (.mclk, .reset, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stored_unlock_code, .chip_reset_req(1'b0),
    .cpu_sleeping, .cpu_halted, .erase_done, .pc_mode, .supply, .lp_mode, .in_transit(1'b0),
    .pc_req, .pc_req_valid, .sysreset_req_wr(1'b0), .debug_grant_ff, .mem_port_status_ff,
    .external_halt_request_ff, .debug_wake_request_ff, .wake_no_exec_ff, .erase_start_ff,
    .sysreset_req_ok_ff, .pc_apply_ff, .pc_apply_mode_ff, .backbias_emul_ff, .in_debug_ff);
  sdag_emu emu (.mclk, .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid), .awready(s_axi_awready),
    .wdata(s_axi_wdata), .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid), .wready(s_axi_wready),
    .bresp(s_axi_bresp), .bvalid(s_axi_bvalid), .bready(s_axi_bready), .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid), .arready(s_axi_arready), .rdata(s_axi_rdata),
    .rvalid(s_axi_rvalid), .rready(s_axi_rready));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // read monitor compares each answer with the oldest note
  always @(posedge mclk) if (s_axi_rvalid && s_axi_rready) chk(s_axi_rdata, exp_q.pop_front());
  // erase start is a one-cycle pulse, so latch it
  always @(posedge mclk) if (erase_start_ff === 1'b1) erase_seen <= 1'b1;
  task rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    exp_q.push_back(e);
    emu.rd(a, d);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    emu.wr(a, d, resp);
  endtask
  // reset then wait out the settle time and the automatic compare
  task rst_wait;
    reset <= 1'b1;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    repeat (16) @(posedge mclk);
  endtask
  task key(input logic [127:0] k);
    for (int i = 0; i < 4; i++) wr(12'(i * 256), k[127 - 32 * i -: 32]);
    repeat (4) @(posedge mclk);
  endtask
  initial begin
    #1000000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    // open code: no key needed, snooze blocks entry
    rst_wait;
    chk(debug_grant_ff, 1);
    chk(in_debug_ff, 0);
    rchk(`SDAG_ADDR_STATUS, 32'h00000001);
    rchk(`SDAG_ADDR_KEY0, 32'h00000000);
    wr(12'h800, 32'h00000000);
    chk(32'(resp), 32'h00000002);
    lp_mode <= `SDAG_LP_SLEEP;
    repeat (3) @(posedge mclk);
    chk(in_debug_ff, 1);
    // halt with wake, then halt cleared by the cpu
    emu.stall = 2;
    wr(`SDAG_ADDR_CTRL, 32'h00000101);
    rchk(`SDAG_ADDR_CTRL, 32'h00000101);
    chk(debug_wake_request_ff, 1);
    chk(wake_no_exec_ff, 1);
    // clock enable low freezes state, so the cpu halt cannot clear it yet
    ce <= 1'b0;
    cpu_halted <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(external_halt_request_ff, 1);
    ce <= 1'b1;
    repeat (3) @(posedge mclk);
    cpu_halted <= 1'b0;
    rchk(`SDAG_ADDR_CTRL, 32'h00000100);
    emu.stall = 0;
    // erase pattern
    key(`SDAG_ERASE_KEY);
    chk(erase_seen, 1);
    chk(sysreset_req_ok_ff, 0);
    erase_done <= 1'b1;
    cpu_sleeping <= 1'b1;
    repeat (2) @(posedge mclk);
    rchk(`SDAG_ADDR_STATUS, 32'h00000007);
    erase_done <= 1'b0;
    cpu_sleeping <= 1'b0;
    // random stored code, one bit wrong in the key
    for (int j = 0; j < 4; j++) begin
      rnd = lfsr(rnd);
      kk[32 * j +: 32] = rnd;
    end
    kk[127] = 1'b1;
    stored_unlock_code <= kk;
    rst_wait;
    chk(debug_grant_ff, 0);
    key(kk ^ (128'h1 << rnd[6:0]));
    chk(debug_grant_ff, 0);
    // exact key, partial key first
    rst_wait;
    for (int i = 0; i < 3; i++) wr(12'(i * 256), kk[127 - 32 * i -: 32]);
    repeat (4) @(posedge mclk);
    chk(debug_grant_ff, 0);
    chk(sysreset_req_ok_ff, 0);
    wr(`SDAG_ADDR_KEY3, kk[31:0]);
    repeat (4) @(posedge mclk);
    chk(mem_port_status_ff, 1);
    chk(in_debug_ff, 1);
    wr(`SDAG_ADDR_DBGCTL, 32'h00000001);
    rchk(`SDAG_ADDR_DBGCTL, 32'h00000003);
    rchk(`SDAG_ADDR_PWR, 32'h00000011);
    // boost refused, back-bias emulated
    for (int m = 0; m < 3; m += 2) begin
      pc_req <= 2'(m);
      pc_req_valid <= 1'b1;
      @(posedge mclk);
      pc_req_valid <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(backbias_emul_ff, m == 2);
      chk(pc_apply_mode_ff, `SDAG_PC_NORMAL);
    end
    stored_unlock_code <= ~kk;
    repeat (4) @(posedge mclk);
    chk(debug_grant_ff, 1);
    // prohibited code: even the exact key fails
    stored_unlock_code <= kk & {1'b0, {127{1'b1}}};
    rst_wait;
    key(kk & {1'b0, {127{1'b1}}});
    chk(debug_grant_ff, 0);
    report_and_stop;
  end
endmodule // tb_top
